// >>> pkg/sdtm_pkg.sv
// Purpose: Shared constants and types of the card command timeout monitor.
// Assumes: System clock of 100 MHz; command fields as sent on the card bus.
// Notes: All limits are held in their own unit; time limits are converted to milliseconds here, the rate window to cycles.
package sdtm_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int US_PER_S = 1_000_000;
  localparam int CYC_PER_MS_DFLT = CLK_HZ / MS_PER_S;

  localparam int MS_W = 10;
  localparam int CYC_W = 17;

  localparam logic [MS_W-1:0] READ_LIMIT_MS = 10'h064;
  localparam logic [MS_W-1:0] WRITE_STD_MS = 10'h0FA;
  localparam logic [MS_W-1:0] WRITE_XC_MS = 10'h1F4;
  localparam int INIT_LIMIT_S = 1;
  localparam logic [MS_W-1:0] INIT_LIMIT_MS = MS_W'(INIT_LIMIT_S * MS_PER_S);

  localparam int WIN_US = 1;
  localparam int WIN_CYC = CLK_HZ / US_PER_S * WIN_US;
  localparam int WIN_W = 7;
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WIN_CYC - 1);
  localparam int EDGE_W = 8;
  localparam int DEF_MAX_MHZ = 25;
  localparam int HS_MAX_MHZ = 50;
  localparam logic [EDGE_W-1:0] DEF_MAX_EDGES = EDGE_W'(DEF_MAX_MHZ * WIN_US);
  localparam logic [EDGE_W-1:0] HS_MAX_EDGES = EDGE_W'(HS_MAX_MHZ * WIN_US);
  localparam logic [EDGE_W-1:0] EDGE_SAT = 8'hFF;
  localparam logic [EDGE_W-1:0] EDGE_STEP = 8'h02;
  localparam logic [EDGE_W-1:0] EDGE_TOP = EDGE_SAT - EDGE_STEP;

  localparam logic [5:0] CMD_GO_IDLE = 6'h00;
  localparam logic [5:0] CMD_ALL_ID = 6'h02;
  localparam logic [5:0] CMD_REL_ADDR = 6'h03;
  localparam logic [5:0] CMD_SET_DRV = 6'h04;
  localparam logic [5:0] CMD_SWITCH = 6'h06;
  localparam logic [5:0] CMD_READ_SPEC = 6'h09;
  localparam logic [5:0] CMD_READ_ID = 6'h0A;
  localparam logic [5:0] CMD_RD_BLOCK = 6'h11;
  localparam logic [5:0] CMD_WR_BLOCK = 6'h18;
  localparam logic [5:0] CMD_APP = 6'h37;
  localparam logic [5:0] ACMD_BUS_WIDTH = 6'h06;
  localparam logic [5:0] ACMD_OP_COND = 6'h29;
  localparam logic [5:0] ACMD_READ_CFG = 6'h33;

  localparam int ARG_WIN_LSB = 15;
  localparam int ARG_WIN_MSB = 23;
  localparam int ARG_HI_LSB = 16;
  localparam int ARG_HI_MSB = 31;
  localparam int ARG_SW_SET = 31;
  localparam int ARG_GRP_MSB = 3;
  localparam int ARG_WID_MSB = 1;
  localparam logic [3:0] HS_FUNC = 4'h1;
  localparam logic [1:0] WIDTH_FOUR = 2'h2;

  localparam int OCR_BUSY_BIT = 31;
  localparam int OCR_CCS_BIT = 30;
  localparam logic [31:0] OCR_WINDOW = 32'h00FF_8000;
  localparam logic [15:0] RCA_RESET = 16'h0000;
  localparam logic [15:0] DSR_RESET = 16'h0404;

  typedef struct packed {
    logic [5:0] index;
    logic [31:0] arg;
  } sdtm_cmd_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_OCR = 3'h1,
    SEL_CID = 3'h2,
    SEL_CSD = 3'h3,
    SEL_RCA = 3'h4,
    SEL_DSR = 3'h5,
    SEL_SCR = 3'h6,
    SEL_STAT = 3'h7
  } sdtm_sel_t;

  typedef struct packed {
    logic valid;
    sdtm_sel_t sel;
    logic [31:0] data;
  } sdtm_resp_t;

  typedef enum logic [1:0] {
    ERR_NONE = 2'h0,
    ERR_READ = 2'h1,
    ERR_WRITE = 2'h2,
    ERR_INIT = 2'h3
  } sdtm_err_kind_t;

  typedef struct packed {
    logic valid;
    sdtm_err_kind_t kind;
  } sdtm_err_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_INIT = 4'h2,
    ST_READ = 4'h4,
    ST_WRITE = 4'h8
  } sdtm_state_t;

endpackage

// >>> logic/sdtm_ms_timer.sv
// Purpose: Millisecond timebase and limit counter for one operation.
// Assumes: Start and stop are one-cycle pulses on the same clock.
// Notes: A start while running restarts the count from zero.
`timescale 1ns/1ps
module sdtm_ms_timer #(
  parameter int CYC_PER_MS = sdtm_pkg::CYC_PER_MS_DFLT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic stop,
  input wire logic [sdtm_pkg::MS_W-1:0] limit_ms,
  output logic expired
);
  import sdtm_pkg::*;

  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(CYC_PER_MS - 1);

  logic run_reg, run_next;
  logic exp_reg, exp_next;
  logic [CYC_W-1:0] cyc_reg, cyc_next;
  logic [MS_W-1:0] ms_reg, ms_next;
  logic [MS_W-1:0] lim_reg, lim_next;

  always_comb begin
    run_next = run_reg;
    cyc_next = cyc_reg;
    ms_next = ms_reg;
    lim_next = lim_reg;
    exp_next = 1'b0;
    if (start) begin
      run_next = 1'b1;
      cyc_next = '0;
      ms_next = '0;
      lim_next = limit_ms;
    end else if (stop) begin
      run_next = 1'b0;
    end else if (run_reg) begin
      if (cyc_reg == CYC_LAST) begin
        cyc_next = '0;
        ms_next = ms_reg + 1'b1;
        if (ms_next == lim_reg) begin
          run_next = 1'b0;
          exp_next = 1'b1;
        end
      end else begin
        cyc_next = cyc_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
      exp_reg <= 1'b0;
      cyc_reg <= '0;
      ms_reg <= '0;
      lim_reg <= '0;
    end else begin
      run_reg <= run_next;
      exp_reg <= exp_next;
      cyc_reg <= cyc_next;
      ms_reg <= ms_next;
      lim_reg <= lim_next;
    end
  end

  assign expired = exp_reg;

endmodule

// >>> logic/sdtm_monitor.sv
// Purpose: Card-side command decoder with read, write and init time limits.
// Assumes: Commands arrive decoded on the bus clock, at most one per 48 edges.
// Notes: Core done pulses and capacity levels come on the system clock.
// Summary of operation
// - Finish within limit, else abandon and report error.
// - Single block read limited to 100 ms.
// - Write limit 250 ms, or 500 ms extended.
// - Init ready within 1 s of first start.
// - Six card registers reached only by commands.
// - Fixed info registers; address and driver settable.
// - Default speed up to 25 MHz, four lines.
// - High speed up to 50 MHz.
// - Ready bit 31 low until power-up done.
`timescale 1ns/1ps
module sdtm_monitor #(
  parameter int CYC_PER_MS = sdtm_pkg::CYC_PER_MS_DFLT
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic SD_CLK,
  input wire logic CMD_STB,
  input wire sdtm_pkg::sdtm_cmd_t CMD_IN,
  input wire logic PWRUP_DONE,
  input wire logic RD_DONE,
  input wire logic WR_DONE,
  input wire logic CAP_CCS,
  input wire logic CAP_XC,
  output sdtm_pkg::sdtm_resp_t RESP,
  output sdtm_pkg::sdtm_err_t ERR,
  output logic CARD_READY,
  output logic BUSY,
  output logic HS_MODE,
  output logic WIDE_BUS,
  output logic CLK_OVER,
  output logic [15:0] CARD_ADDR,
  output logic [15:0] DRV_STAGE
);
  import sdtm_pkg::*;

  // Bus clock domain: latch each command and flag it by a toggle.
  sdtm_cmd_t lcmd_reg, lcmd_next;
  logic ltog_reg, ltog_next;
  logic ledge_reg, ledge_next;
  logic lhalf_reg, lhalf_next;

  always_comb begin
    lcmd_next = lcmd_reg;
    ltog_next = ltog_reg;
    // Toggle on every second bus edge: each level then lasts two bus
    // periods, so the synchroniser keeps up with bus clocks to 100 MHz.
    lhalf_next = ~lhalf_reg;
    ledge_next = ledge_reg ^ lhalf_reg;
    if (CMD_STB) begin
      lcmd_next = CMD_IN;
      ltog_next = ~ltog_reg;
    end
  end

  always_ff @(posedge SD_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lcmd_reg <= '0;
      ltog_reg <= 1'b0;
      ledge_reg <= 1'b0;
      lhalf_reg <= 1'b0;
    end else begin
      lcmd_reg <= lcmd_next;
      ltog_reg <= ltog_next;
      ledge_reg <= ledge_next;
      lhalf_reg <= lhalf_next;
    end
  end

  // System domain: three-stage synchronisers for both toggles.
  // The latched command is only read after its toggle has settled, and the
  // next command comes many bus edges later, so the word is stable then.
  logic [2:0] ctog_sync_reg, ctog_sync_next;
  logic [2:0] etog_sync_reg, etog_sync_next;
  logic cacc_reg, cacc_next;
  logic eacc_reg, eacc_next;
  logic cmd_evt, edge_evt;

  always_comb begin
    ctog_sync_next = {ctog_sync_reg[1:0], ltog_reg};
    etog_sync_next = {etog_sync_reg[1:0], ledge_reg};
    cmd_evt = (ctog_sync_reg[2] == ctog_sync_reg[1]) &&
              (ctog_sync_reg[2] != cacc_reg);
    edge_evt = (etog_sync_reg[2] == etog_sync_reg[1]) &&
               (etog_sync_reg[2] != eacc_reg);
    cacc_next = cmd_evt ? ctog_sync_reg[2] : cacc_reg;
    eacc_next = edge_evt ? etog_sync_reg[2] : eacc_reg;
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctog_sync_reg <= '0;
      etog_sync_reg <= '0;
      cacc_reg <= 1'b0;
      eacc_reg <= 1'b0;
    end else begin
      ctog_sync_reg <= ctog_sync_next;
      etog_sync_reg <= etog_sync_next;
      cacc_reg <= cacc_next;
      eacc_reg <= eacc_next;
    end
  end

  // Bus clock rate check over a fixed window of system cycles.
  // Each event stands for two bus edges and the count saturates. Above
  // 100 MHz events are lost, so the check is meant for slower clocks.
  logic [WIN_W-1:0] win_reg, win_next;
  logic [EDGE_W-1:0] edges_reg, edges_next;
  logic over_reg, over_next;
  logic hs_reg, hs_next;
  logic [EDGE_W-1:0] edge_lim;

  always_comb begin
    win_next = win_reg + 1'b1;
    edges_next = edges_reg;
    over_next = over_reg;
    edge_lim = hs_reg ? HS_MAX_EDGES : DEF_MAX_EDGES;
    if (edge_evt && (edges_reg < EDGE_TOP)) begin
      edges_next = edges_reg + EDGE_STEP;
    end
    if (win_reg == WIN_LAST) begin
      win_next = '0;
      edges_next = '0;
      over_next = (edges_reg > edge_lim);
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      win_reg <= '0;
      edges_reg <= '0;
      over_reg <= 1'b0;
    end else begin
      win_reg <= win_next;
      edges_reg <= edges_next;
      over_reg <= over_next;
    end
  end

  // Operation timer in milliseconds.
  logic t_start, t_stop, t_exp;
  logic [MS_W-1:0] t_limit;

  sdtm_ms_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_timer (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .start(t_start),
    .stop(t_stop),
    .limit_ms(t_limit),
    .expired(t_exp)
  );

  // Card state and command decode.
  sdtm_state_t state_reg, state_next;
  sdtm_resp_t resp_reg, resp_next;
  sdtm_err_t err_reg, err_next;
  logic app_reg, app_next;
  logic ready_reg, ready_next;
  logic ccs_reg, ccs_next;
  logic wide_reg, wide_next;
  logic busy_reg, busy_next;
  logic [15:0] rca_reg, rca_next;
  logic [15:0] dsr_reg, dsr_next;
  logic [31:0] ocr_val;
  logic win_set, op_busy;
  sdtm_cmd_t c;

  always_comb begin
    c = lcmd_reg;
    state_next = state_reg;
    resp_next = '0;
    err_next = '0;
    app_next = app_reg;
    ready_next = ready_reg;
    ccs_next = ccs_reg;
    wide_next = wide_reg;
    hs_next = hs_reg;
    rca_next = rca_reg;
    dsr_next = dsr_reg;
    t_start = 1'b0;
    t_stop = 1'b0;
    t_limit = READ_LIMIT_MS;
    ocr_val = OCR_WINDOW;
    ocr_val[OCR_BUSY_BIT] = ready_reg;
    ocr_val[OCR_CCS_BIT] = ready_reg & ccs_reg;
    win_set = |c.arg[ARG_WIN_MSB:ARG_WIN_LSB];
    op_busy = (state_reg == ST_READ) || (state_reg == ST_WRITE);

    // A done pulse in the expiry cycle counts as finished in time.
    unique case (state_reg)
      ST_IDLE: begin
      end
      ST_INIT: begin
        if (PWRUP_DONE) begin
          ready_next = 1'b1;
          ccs_next = CAP_CCS;
          t_stop = 1'b1;
          state_next = ST_IDLE;
        end else if (t_exp) begin
          err_next = '{valid: 1'b1, kind: ERR_INIT};
          state_next = ST_IDLE;
        end
      end
      ST_READ: begin
        if (RD_DONE) begin
          t_stop = 1'b1;
          state_next = ST_IDLE;
        end else if (t_exp) begin
          err_next = '{valid: 1'b1, kind: ERR_READ};
          state_next = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (WR_DONE) begin
          t_stop = 1'b1;
          state_next = ST_IDLE;
        end else if (t_exp) begin
          err_next = '{valid: 1'b1, kind: ERR_WRITE};
          state_next = ST_IDLE;
        end
      end
    endcase

    if (cmd_evt && (c.index == CMD_GO_IDLE)) begin
      state_next = ST_IDLE;
      t_stop = 1'b1;
      app_next = 1'b0;
      ready_next = 1'b0;
      ccs_next = 1'b0;
      wide_next = 1'b0;
      hs_next = 1'b0;
      rca_next = RCA_RESET;
      dsr_next = DSR_RESET;
    end else if (cmd_evt && !op_busy) begin
      app_next = (c.index == CMD_APP);
      if (app_reg) begin
        if (c.index == ACMD_OP_COND) begin
          resp_next = '{valid: 1'b1, sel: SEL_OCR, data: ocr_val};
          if (win_set && !ready_reg && (state_reg == ST_IDLE)) begin
            t_start = 1'b1;
            t_limit = INIT_LIMIT_MS;
            state_next = ST_INIT;
          end
        end else if (ready_reg && (c.index == ACMD_BUS_WIDTH)) begin
          wide_next = (c.arg[ARG_WID_MSB:0] == WIDTH_FOUR);
          resp_next = '{valid: 1'b1, sel: SEL_STAT, data: '0};
        end else if (ready_reg && (c.index == ACMD_READ_CFG)) begin
          resp_next = '{valid: 1'b1, sel: SEL_SCR, data: '0};
        end
      end else if (ready_reg) begin
        if ((c.index == CMD_ALL_ID) || (c.index == CMD_READ_ID)) begin
          resp_next = '{valid: 1'b1, sel: SEL_CID, data: '0};
        end else if (c.index == CMD_READ_SPEC) begin
          resp_next = '{valid: 1'b1, sel: SEL_CSD, data: '0};
        end else if (c.index == CMD_REL_ADDR) begin
          rca_next = c.arg[ARG_HI_MSB:ARG_HI_LSB];
          resp_next = '{valid: 1'b1, sel: SEL_RCA,
                        data: {c.arg[ARG_HI_MSB:ARG_HI_LSB], 16'h0000}};
        end else if (c.index == CMD_SET_DRV) begin
          dsr_next = c.arg[ARG_HI_MSB:ARG_HI_LSB];
        end else if (c.index == CMD_SWITCH) begin
          if (c.arg[ARG_SW_SET]) begin
            hs_next = (c.arg[ARG_GRP_MSB:0] == HS_FUNC);
          end
          resp_next = '{valid: 1'b1, sel: SEL_STAT, data: '0};
        end else if (c.index == CMD_RD_BLOCK) begin
          t_start = 1'b1;
          t_limit = READ_LIMIT_MS;
          state_next = ST_READ;
        end else if (c.index == CMD_WR_BLOCK) begin
          t_start = 1'b1;
          t_limit = CAP_XC ? WRITE_XC_MS : WRITE_STD_MS;
          state_next = ST_WRITE;
        end
      end
    end
    busy_next = (state_next != ST_IDLE);
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= ST_IDLE;
      resp_reg <= '0;
      err_reg <= '0;
      app_reg <= 1'b0;
      ready_reg <= 1'b0;
      ccs_reg <= 1'b0;
      wide_reg <= 1'b0;
      hs_reg <= 1'b0;
      busy_reg <= 1'b0;
      rca_reg <= RCA_RESET;
      dsr_reg <= DSR_RESET;
    end else begin
      state_reg <= state_next;
      resp_reg <= resp_next;
      err_reg <= err_next;
      app_reg <= app_next;
      ready_reg <= ready_next;
      ccs_reg <= ccs_next;
      wide_reg <= wide_next;
      hs_reg <= hs_next;
      busy_reg <= busy_next;
      rca_reg <= rca_next;
      dsr_reg <= dsr_next;
    end
  end

  assign RESP = resp_reg;
  assign ERR = err_reg;
  assign CARD_READY = ready_reg;
  assign BUSY = busy_reg;
  assign HS_MODE = hs_reg;
  assign WIDE_BUS = wide_reg;
  assign CLK_OVER = over_reg;
  assign CARD_ADDR = rca_reg;
  assign DRV_STAGE = dsr_reg;

endmodule

// >>> bench/sdtm_host_model.sv
// Purpose: Host controller model that sends command frames on the link.
// Assumes: Link clock stands still low between frames.
// Notes: Released command lines show the inverse of the last value.
`timescale 1ns/1ps
module sdtm_host_model (
  output logic SD_CLK,
  output logic CMD_STB,
  output sdtm_pkg::sdtm_cmd_t CMD_IN
);
  import sdtm_pkg::*;
  initial begin
    SD_CLK = 1'b0;
    CMD_STB = 1'b0;
    CMD_IN = '0;
  end
  task automatic burst(input int n, input int hp);
    repeat (n) begin
      #hp SD_CLK = 1'b1;
      #hp SD_CLK = 1'b0;
    end
  endtask
  // Registers are only reached by a whole command frame.
  task automatic send(input logic [5:0] idx, input logic [31:0] arg);
    burst(2, 6);
    CMD_STB = 1'b1;
    CMD_IN = {idx, arg};
    burst(1, 6);
    CMD_STB = 1'b0;
    CMD_IN = ~CMD_IN;
    burst(2, 6);
  endtask
endmodule

// >>> bench/sdtm_monitor_properties.sv
// Purpose: Port-level timing checks of the command timeout monitor.
// Assumes: CYC_PER_MS equals the value of the bound instance.
// Notes: Limits allow four cycles either way of the count taken while BUSY is high, after the link synchroniser.
`timescale 1ns/1ps
module sdtm_monitor_chk #(
  parameter int CYC_PER_MS = sdtm_pkg::CYC_PER_MS_DFLT
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic PWRUP_DONE,
  input wire sdtm_pkg::sdtm_resp_t RESP,
  input wire sdtm_pkg::sdtm_err_t ERR,
  input wire logic CARD_READY,
  input wire logic BUSY,
  input wire logic [15:0] CARD_ADDR,
  input wire logic [15:0] DRV_STAGE
);
  import sdtm_pkg::*;
  int busy_reg;
  int busy_next;
  always_comb busy_next = BUSY ? busy_reg + 1 : 0;
  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N) busy_reg <= 0;
    else busy_reg <= busy_next;
  function automatic bit near(input int v, input int ms);
    return v >= ms * CYC_PER_MS - 4 && v <= ms * CYC_PER_MS + 4;
  endfunction
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  property p_err_pulse; ERR.valid |=> !ERR.valid; endproperty
  a_err_pulse: assert property (p_err_pulse)
    else $error("error pulse longer than one cycle");
  property p_err_busy; ERR.valid |-> $past(BUSY) ##1 !BUSY; endproperty
  a_err_busy: assert property (p_err_busy)
    else $error("error not ending a busy operation");
  property p_busy_cap; busy_reg <= 1000 * CYC_PER_MS + 4; endproperty
  a_busy_cap: assert property (p_busy_cap)
    else $error("operation outlived every limit");
  property p_read_lim;
    ERR.valid && ERR.kind == ERR_READ |-> near(busy_reg, 100);
  endproperty
  a_read_lim: assert property (p_read_lim)
    else $error("read timeout at wrong time");
  property p_write_lim;
    ERR.valid && ERR.kind == ERR_WRITE |->
      near(busy_reg, 250) || near(busy_reg, 500);
  endproperty
  a_write_lim: assert property (p_write_lim)
    else $error("write timeout at wrong time");
  property p_init_lim;
    ERR.valid && ERR.kind == ERR_INIT |-> near(busy_reg, 1000);
  endproperty
  a_init_lim: assert property (p_init_lim)
    else $error("init timeout at wrong time");
  property p_ready;
    PWRUP_DONE && BUSY && !CARD_READY |=> CARD_READY && !BUSY;
  endproperty
  a_ready: assert property (p_ready)
    else $error("power-up done did not make the card ready");
  property p_ocr;
    RESP.valid && RESP.sel == SEL_OCR |-> RESP.data[31] == CARD_READY
      && RESP.data[31:30] != 2'h1 && RESP.data[23:15] == 9'h1FF;
  endproperty
  a_ocr: assert property (p_ocr)
    else $error("condition register value wrong");
  property p_resp_pulse; RESP.valid |=> !RESP.valid; endproperty
  a_resp_pulse: assert property (p_resp_pulse)
    else $error("response longer than one cycle");
  property p_cfg_rst;
    $rose(RESET_N) |-> DRV_STAGE == 16'h0404 && CARD_ADDR == 16'h0000;
  endproperty
  a_cfg_rst: assert property (p_cfg_rst)
    else $error("settable registers not at reset value");
  cover property (ERR.valid && ERR.kind == ERR_INIT);
  cover property ($rose(CARD_READY));
  cover property (RESP.valid && RESP.sel == SEL_RCA);
endmodule
bind sdtm_monitor sdtm_monitor_chk #(.CYC_PER_MS(CYC_PER_MS)) i_chk (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .PWRUP_DONE(PWRUP_DONE),
  .RESP(RESP), .ERR(ERR), .CARD_READY(CARD_READY), .BUSY(BUSY),
  .CARD_ADDR(CARD_ADDR), .DRV_STAGE(DRV_STAGE));

// >>> bench/tb_top.sv
// Purpose: Self-checking bench of the command timeout monitor.
// Assumes: One millisecond is shortened to 10 cycles.
// Notes: Timeouts are judged in cycles counted after the command.
`timescale 1ns/1ps
module tb_top;
  import sdtm_pkg::*;
  localparam int CPM = 10;
  logic CLOCK, RESET_N, SD_CLK, CMD_STB, PWRUP_DONE, RD_DONE, WR_DONE;
  logic CAP_CCS, CAP_XC, CARD_READY, BUSY, HS_MODE, WIDE_BUS, CLK_OVER;
  logic [15:0] CARD_ADDR, DRV_STAGE;
  sdtm_cmd_t CMD_IN;
  sdtm_resp_t RESP, rsp;
  sdtm_err_t ERR;
  int fails, tests_run;
  sdtm_host_model i_host (.SD_CLK(SD_CLK), .CMD_STB(CMD_STB),
    .CMD_IN(CMD_IN));
  sdtm_monitor #(.CYC_PER_MS(CPM)) i_dut (.CLOCK(CLOCK),
    .RESET_N(RESET_N), .SD_CLK(SD_CLK), .CMD_STB(CMD_STB),
    .CMD_IN(CMD_IN), .PWRUP_DONE(PWRUP_DONE), .RD_DONE(RD_DONE),
    .WR_DONE(WR_DONE), .CAP_CCS(CAP_CCS), .CAP_XC(CAP_XC), .RESP(RESP),
    .ERR(ERR), .CARD_READY(CARD_READY), .BUSY(BUSY), .HS_MODE(HS_MODE),
    .WIDE_BUS(WIDE_BUS), .CLK_OVER(CLK_OVER), .CARD_ADDR(CARD_ADDR),
    .DRV_STAGE(DRV_STAGE));
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  // The response lasts one cycle, so keep the last one for the checks;
  // a new strobe clears it, so a missing answer cannot look like one.
  always @(posedge CLOCK) begin
    if (RESP.valid === 1'b1) begin
      rsp <= RESP;
    end else if (CMD_STB === 1'b1) begin
      rsp <= '0;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  task automatic chk(input logic [37:0] exp, input logic [37:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg);
    i_host.send(idx, arg);
    tick(8);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask
  task automatic wait_err(input sdtm_err_kind_t kind, input int ms);
    int n;
    n = 0;
    while (ERR.valid !== 1'b1 && n < ms * CPM + 30) begin
      tick(1);
      n++;
    end
    chk(38'(kind), 38'(ERR.kind));
    chk(38'(1'b1), 38'(n > ms * CPM - 25));
    if (n >= ms * CPM + 30) final_report();
    tick(2);
  endtask
  task automatic rate(input int hp, input logic exp);
    i_host.burst(1500 / hp, hp);
    tick(1);
    chk(38'(exp), 38'(CLK_OVER));
  endtask
  task automatic t_reset;
    chk(38'(36'h0_0000_0404), 38'({4'h0, CARD_ADDR, DRV_STAGE}));
    chk(38'(4'h0), 38'({CARD_READY, BUSY, HS_MODE, WIDE_BUS}));
    cmd(CMD_REL_ADDR, 32'h1234_0000);
    chk(38'(17'h0), 38'({rsp.valid, CARD_ADDR}));
    $display("reset test done");
  endtask
  task automatic t_init;
    cmd(CMD_APP, 32'h0);
    cmd(ACMD_OP_COND, 32'h0);
    chk(38'({1'b1, SEL_OCR, 1'b0}), 38'({rsp.valid, rsp.sel, BUSY}));
    repeat (2) begin
      cmd(CMD_APP, 32'h0);
      cmd(ACMD_OP_COND, OCR_WINDOW);
      chk(38'(3'h5), 38'({rsp.valid, rsp.data[31], BUSY}));
    end
    CAP_CCS = 1'b1;
    pulse(PWRUP_DONE);
    chk(38'(2'h2), 38'({CARD_READY, BUSY}));
    cmd(CMD_APP, 32'h0);
    cmd(ACMD_OP_COND, OCR_WINDOW);
    chk(38'(34'h3_81FF_0000), 38'({rsp.valid, rsp.data, BUSY}));
    $display("init test done");
  endtask
  task automatic t_regs;
    cmd(CMD_REL_ADDR, 32'hA5C3_0000);
    chk(38'({SEL_RCA, 32'hA5C3_0000}), 38'({rsp.sel, rsp.data}));
    chk(38'(16'hA5C3), 38'(CARD_ADDR));
    cmd(CMD_SET_DRV, 32'h0F0F_0000);
    chk(38'(17'h0F0F), 38'({rsp.valid, DRV_STAGE}));
    cmd(CMD_READ_SPEC, 32'h0);
    chk(38'({1'b1, SEL_CSD}), 38'({rsp.valid, rsp.sel}));
    cmd(CMD_ALL_ID, 32'h0);
    chk(38'({1'b1, SEL_CID}), 38'({rsp.valid, rsp.sel}));
    cmd(CMD_APP, 32'h0);
    cmd(ACMD_READ_CFG, 32'h0);
    chk(38'({1'b1, SEL_SCR}), 38'({rsp.valid, rsp.sel}));
    cmd(CMD_APP, 32'h0);
    cmd(ACMD_BUS_WIDTH, 32'h2);
    chk(38'(2'h1), 38'({HS_MODE, WIDE_BUS}));
    rate(12, 1'b1);
    cmd(CMD_SWITCH, 32'h8000_0001);
    chk(38'(1'b1), 38'(HS_MODE));
    rate(12, 1'b0);
    rate(6, 1'b1);
    $display("register test done");
  endtask
  task automatic t_rw;
    cmd(CMD_RD_BLOCK, 32'h0);
    cmd(CMD_REL_ADDR, 32'h1111_0000);
    chk(38'(17'h1_A5C3), 38'({BUSY, CARD_ADDR}));
    pulse(RD_DONE);
    chk(38'(1'b0), 38'(BUSY));
    cmd(CMD_RD_BLOCK, 32'h0);
    wait_err(ERR_READ, 100);
    cmd(CMD_WR_BLOCK, 32'h0);
    wait_err(ERR_WRITE, 250);
    CAP_XC = 1'b1;
    cmd(CMD_WR_BLOCK, 32'h0);
    wait_err(ERR_WRITE, 500);
    cmd(CMD_WR_BLOCK, 32'h0);
    pulse(WR_DONE);
    chk(38'(1'b0), 38'(BUSY));
    $display("read write test done");
  endtask
  task automatic t_init_to;
    cmd(CMD_GO_IDLE, 32'h0);
    chk(38'(1'b0), 38'(CARD_READY));
    cmd(CMD_APP, 32'h0);
    cmd(ACMD_OP_COND, OCR_WINDOW);
    wait_err(ERR_INIT, 1000);
    $display("init timeout test done");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    RESET_N = 1'b0;
    {PWRUP_DONE, RD_DONE, WR_DONE, CAP_CCS, CAP_XC} = 5'h00;
    fails = 0;
    tests_run = 0;
    tick(3);
    i_host.burst(4, 6);
    tick(9);
    RESET_N = 1'b1;
    t_reset();
    t_init();
    t_regs();
    t_rw();
    t_init_to();
    final_report();
  end
endmodule
